// [flash_erase_host.sv]
// host controller driving a byte-wide flash for chip erase and suspend
`default_nettype none
module flash_erase_host
  import flash_erase_pkg::*;
#(
  parameter int VCS_CYCLES  = VCS_CYC,   // power-up wait
  parameter int SUSP_CYCLES = SUSP_CYC   // suspend settle wait
)(
  input  wire logic        clk,          // 100 MHz clock
  input  wire logic        rst_n,        // sync reset, active low
  input  wire logic        clkEn,        // freezes all state when low
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb direction
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic             pready,       // apb ready
  output logic [31:0]      prdata,       // apb read data
  output logic             pslverr,      // apb error
  output logic [17:0]      flashAddr,    // flash address pins
  output logic [7:0]       flashDqOut,   // flash data driven
  output logic             flashDqOe,    // data enable, low drives
  input  wire logic [7:0]  flashDqIn,    // flash data sampled
  output logic             chipEn_n,     // chip enable
  output logic             writeEn_n,    // write enable
  output logic             outEn_n       // output enable
);
  typedef enum {
    S_PWRUP, S_IDLE, S_WSET, S_WLOW, S_WHIGH, S_RLOW, S_RSAMP, S_POLL,
    S_SETTLE
  } state_e;

  // ==========================================================
  // command sequencing state
  state_e      state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0]  step_q;       // index into current write list
  logic [2:0]  nSteps_q;     // writes in current instruction
  logic [2:0]  op_q;         // which instruction runs
  logic        ctrlWr;       // control word written this cycle
  logic        pend_q;       // suspend or reset waiting for poll gap
  logic [2:0]  pendOp_q;     // which of the two is waiting
  logic        pollDone;     // poll line shows completion
  logic [17:0] progAddr_q;
  logic [7:0]  progData_q;
  logic [7:0]  readData_q;
  logic [7:0]  lastStat_q;
  logic        havePrev_q;
  logic        busy_q, done_q, fail_q, susp_q;
  logic [17:0] wAddr;
  logic [7:0]  wData;
  logic [7:0]  sampled;
  logic [7:0]  dqS1_q, dqS2_q, dqS3_q, dqHeld_q;
  logic        cmdHit;
  logic [5:0]  cmdBits;

  localparam logic [2:0] OP_ERASE = 3'd0;
  localparam logic [2:0] OP_SUSP  = 3'd1;
  localparam logic [2:0] OP_RES   = 3'd2;
  localparam logic [2:0] OP_PROG  = 3'd3;
  localparam logic [2:0] OP_READ  = 3'd4;
  localparam logic [2:0] OP_RST   = 3'd5;

  // three-stage sampler on the asynchronous data pins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dqS1_q <= 8'h00;
      dqS2_q <= 8'h00;
      dqS3_q <= 8'h00;
      dqHeld_q <= 8'h00;
    end
    else if (clkEn)
    begin
      dqS1_q <= flashDqIn;
      dqS2_q <= dqS1_q;
      dqS3_q <= dqS2_q;
      if (dqS2_q == dqS3_q)
        dqHeld_q <= dqS3_q;
    end
  end
  // data counts once the two later stages agree
  assign sampled = dqHeld_q;

  // address and data of each write step
  always_comb
  begin
    wAddr = ADDR_UNLOCK1;
    wData = CMD_RESET;
    case (op_q)
      OP_ERASE:
      begin
        case (step_q)
          3'd0: begin wAddr = ADDR_UNLOCK1; wData = CMD_UNLOCK1; end
          3'd1: begin wAddr = ADDR_UNLOCK2; wData = CMD_UNLOCK2; end
          3'd2: begin wAddr = ADDR_UNLOCK1; wData = CMD_SETUP;   end
          3'd3: begin wAddr = ADDR_UNLOCK1; wData = CMD_UNLOCK1; end
          3'd4: begin wAddr = ADDR_UNLOCK2; wData = CMD_UNLOCK2; end
          default: begin wAddr = ADDR_UNLOCK1; wData = CMD_CONFIRM; end
        endcase
      end
      OP_SUSP:  begin wAddr = progAddr_q; wData = CMD_SUSPEND; end
      OP_RES:   begin wAddr = progAddr_q; wData = CMD_RESUME;  end
      OP_PROG:
      begin
        case (step_q)
          3'd0: begin wAddr = ADDR_UNLOCK1; wData = CMD_UNLOCK1; end
          3'd1: begin wAddr = ADDR_UNLOCK2; wData = CMD_UNLOCK2; end
          3'd2: begin wAddr = ADDR_UNLOCK1; wData = CMD_PROGRAM; end
          default: begin wAddr = progAddr_q; wData = progData_q; end
        endcase
      end
      default: begin wAddr = progAddr_q; wData = CMD_RESET; end
    endcase
  end

  // apb write of control starts an instruction when idle
  assign ctrlWr  = psel && penable && pwrite && paddr == OFS_CTRL;
  assign cmdHit  = ctrlWr && state_q == S_IDLE;

  // a program ends when the poll line shows the true data bit
  assign pollDone = (op_q == OP_PROG)
                    ? sampled[POLL_BIT] == progData_q[POLL_BIT]
                    : sampled[POLL_BIT];

  // suspend or reset written mid-erase waits for the next poll gap,
  // since the sequencer never idles while an erase runs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pend_q   <= 1'b0;
      pendOp_q <= OP_SUSP;
    end
    else if (clkEn)
    begin
      if (ctrlWr && state_q != S_IDLE && !pend_q &&
          (op_q == OP_ERASE || op_q == OP_RES) &&
          (cmdBits[CTRL_SUSPEND] || cmdBits[CTRL_RESET]))
      begin
        pend_q   <= 1'b1;
        pendOp_q <= cmdBits[CTRL_SUSPEND] ? OP_SUSP : OP_RST;
      end
      else if (state_q == S_POLL || state_q == S_IDLE)
        pend_q <= 1'b0;
    end
  end
  assign cmdBits = pwdata[5:0];

  // ==========================================================
  // flash pin sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q    <= S_PWRUP; // array read after power-up
      cnt_q      <= '0;
      step_q     <= 3'd0;
      nSteps_q   <= 3'd0;
      op_q       <= OP_READ;
      chipEn_n   <= 1'b1;  // strobes high through power-up
      writeEn_n  <= 1'b1;
      outEn_n    <= 1'b1;
      flashDqOe  <= 1'b1;
      flashAddr  <= '0;
      flashDqOut <= 8'h00;
      readData_q <= 8'h00;
      lastStat_q <= 8'h00;
      havePrev_q <= 1'b0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      fail_q     <= 1'b0;
      susp_q     <= 1'b0;
    end
    else if (clkEn)
    begin
      case (state_q)
        // wait for supply before the first write
        S_PWRUP:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(VCS_CYCLES))
            state_q <= S_IDLE;
        end
        S_IDLE:
        begin
          step_q <= 3'd0;
          cnt_q  <= '0;
          if (cmdHit)
          begin
            done_q <= 1'b0;
            if (cmdBits[CTRL_ERASE] && !busy_q && !susp_q)
            begin
              op_q <= OP_ERASE; nSteps_q <= 3'd6;
              fail_q <= 1'b0; state_q <= S_WSET;
            end
            else if (cmdBits[CTRL_SUSPEND] && busy_q)
            begin
              op_q <= OP_SUSP; nSteps_q <= 3'd1; state_q <= S_WSET;
            end
            else if (cmdBits[CTRL_RESUME] && susp_q)
            begin
              op_q <= OP_RES; nSteps_q <= 3'd1; state_q <= S_WSET;
            end
            else if (cmdBits[CTRL_PROGRAM] && (susp_q || !busy_q))
            begin
              op_q <= OP_PROG; nSteps_q <= 3'd4; state_q <= S_WSET;
            end
            else if (cmdBits[CTRL_RESET])
            begin
              op_q <= OP_RST; nSteps_q <= 3'd1; state_q <= S_WSET;
            end
            else if (cmdBits[CTRL_READ] && !busy_q)
            begin
              op_q <= OP_READ; state_q <= S_RLOW;
            end
          end
        end
        // present address with output enable high
        S_WSET:
        begin
          outEn_n    <= 1'b1;
          chipEn_n   <= 1'b0;
          flashAddr  <= wAddr;
          flashDqOut <= wData;
          flashDqOe  <= 1'b0;
          cnt_q      <= '0;
          state_q    <= S_WLOW;
        end
        // device latches address on this fall
        S_WLOW:
        begin
          writeEn_n <= 1'b0;
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(WP_CYC))
          begin
            writeEn_n <= 1'b1;  // data latched on rise
            cnt_q <= '0;
            state_q <= S_WHIGH;
          end
        end
        S_WHIGH:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(WPH_CYC))
          begin
            chipEn_n  <= 1'b1;
            flashDqOe <= 1'b1;
            cnt_q <= '0;
            if (step_q + 3'd1 < nSteps_q)
            begin
              step_q  <= step_q + 3'd1;
              state_q <= S_WSET;
            end
            else
            begin
              havePrev_q <= 1'b0;
              case (op_q)
                OP_ERASE: begin busy_q <= 1'b1; state_q <= S_POLL; end
                OP_SUSP:  state_q <= S_SETTLE;
                OP_RES:   begin susp_q <= 1'b0; busy_q <= 1'b1;
                            state_q <= S_POLL; end
                OP_PROG:  state_q <= S_POLL;
                default:  begin busy_q <= 1'b0; susp_q <= 1'b0;
                            done_q <= 1'b1; state_q <= S_IDLE; end
              endcase
            end
          end
        end
        // a read cycle: array data or status bits
        S_RLOW:
        begin
          chipEn_n  <= 1'b0;
          outEn_n   <= 1'b0;
          flashDqOe <= 1'b1;
          if (op_q == OP_READ)
            flashAddr <= progAddr_q;
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(RD_CYC))
            state_q <= S_RSAMP;
        end
        S_RSAMP:
        begin
          chipEn_n <= 1'b1;
          outEn_n  <= 1'b1;
          cnt_q    <= '0;
          readData_q <= sampled;
          havePrev_q <= 1'b1;
          lastStat_q <= sampled;
          if (op_q == OP_READ)
          begin
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
          // toggles still moving means still working
          else if (havePrev_q &&
                   sampled[TOGGLE_A] == lastStat_q[TOGGLE_A] &&
                   sampled[TOGGLE_B] == lastStat_q[TOGGLE_B] &&
                   pollDone)
          begin
            busy_q <= (op_q == OP_PROG) ? busy_q : 1'b0;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
          else if (sampled[ERROR_BIT] && !pollDone &&
                   havePrev_q &&
                   sampled[TOGGLE_A] != lastStat_q[TOGGLE_A])
          begin
            fail_q <= 1'b1;
            busy_q <= (op_q == OP_PROG) ? busy_q : 1'b0;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
          else
            state_q <= S_POLL;
        end
        // release the bus for two cycles between polls
        S_POLL:
        begin
          if (pend_q)
          begin
            op_q     <= pendOp_q;
            nSteps_q <= 3'd1;
            step_q   <= 3'd0;
            state_q  <= S_WSET;
          end
          else
            state_q <= S_RLOW;
        end
        // wait for the device to stop toggling
        S_SETTLE:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(SUSP_CYCLES))
          begin
            busy_q <= 1'b0;
            susp_q <= 1'b1;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // apb slave: address and data registers, status readback
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      progAddr_q <= '0;
      progData_q <= 8'h00;
    end
    else if (clkEn && psel && penable && pwrite)
    begin
      if (paddr == OFS_ADDR)
        progAddr_q <= pwdata[17:0];
      if (paddr == OFS_DATA)
        progData_q <= pwdata[7:0];
    end
  end

  // zero-wait apb answers; unmapped offsets give slverr
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (clkEn)
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable)
      begin
        case (paddr)
          OFS_CTRL:   prdata <= '0;
          OFS_ADDR:   prdata <= {14'h0000, progAddr_q};
          OFS_DATA:   prdata <= {24'h000000, readData_q};
          OFS_STATUS: prdata <= {20'h00000, lastStat_q,
                                 susp_q, fail_q, done_q,
                                 busy_q || state_q != S_IDLE};
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // flash_erase_host
`default_nettype wire

// [flash_erase_host_monitor.sv]
// assertions on the flash erase host ports
`default_nettype none
module flash_erase_host_monitor (
  input wire logic        clk,        // clock
  input wire logic        rst_n,      // sync reset
  input wire logic        psel,       // apb select
  input wire logic        penable,    // apb access
  input wire logic        pready,     // apb ready
  input wire logic        pslverr,    // apb error
  input wire logic [17:0] flashAddr,  // address pins
  input wire logic [7:0]  flashDqOut, // host data
  input wire logic        flashDqOe,  // low drives
  input wire logic        chipEn_n,   // chip enable
  input wire logic        writeEn_n,  // write enable
  input wire logic        outEn_n     // output enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // bus answer and strobe shapes
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_reset_park: assert property (disable iff (1'b0)
    !rst_n |=> chipEn_n && writeEn_n && flashDqOe)
    else $error("strobes not parked in reset");
  a_we_in_ce: assert property (!writeEn_n |-> !chipEn_n)
    else $error("write strobe outside chip enable");
  a_oe_quiet: assert property (!writeEn_n |-> outEn_n)
    else $error("output enable low in a write");
  a_dq_owner: assert property (!flashDqOe |-> outEn_n)
    else $error("host drives data while read enabled");
  // low phase is five cycles (50 ns), then a gap of at least three
  a_we_width: assert property ($fell(writeEn_n) |->
    (!writeEn_n)[*5] ##1 writeEn_n)
    else $error("write pulse width wrong");
  a_we_gap: assert property ($rose(writeEn_n) |-> writeEn_n[*3])
    else $error("write high gap too short");
  a_addr_hold: assert property (!writeEn_n && !$fell(writeEn_n)
    |-> $stable(flashAddr) && $stable(flashDqOut))
    else $error("address or data moved in write pulse");
endmodule // flash_erase_host_monitor
`default_nettype wire

// [flash_erase_pkg.sv]
// constants for the flash whole-array erase host controller
`default_nettype none
package flash_erase_pkg;
  // command codes and addresses (unlock values are customary)
  localparam logic [7:0]  CMD_UNLOCK1   = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2   = 8'h55;
  localparam logic [7:0]  CMD_SETUP     = 8'h80;
  localparam logic [7:0]  CMD_CONFIRM   = 8'h10;
  localparam logic [7:0]  CMD_SUSPEND   = 8'hb0;
  localparam logic [7:0]  CMD_RESUME    = 8'h30;
  localparam logic [7:0]  CMD_PROGRAM   = 8'ha0;
  localparam logic [7:0]  CMD_RESET     = 8'hf0;
  localparam logic [17:0] ADDR_UNLOCK1  = 18'h00555;
  localparam logic [17:0] ADDR_UNLOCK2  = 18'h002aa;
  // status bit positions on the data lines
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_A   = 6;
  localparam int ERROR_BIT  = 5;
  localparam int TOGGLE_B   = 2;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  // control register fields (write one to start)
  localparam int CTRL_ERASE   = 0;
  localparam int CTRL_SUSPEND = 1;
  localparam int CTRL_RESUME  = 2;
  localparam int CTRL_PROGRAM = 3;
  localparam int CTRL_READ    = 4;
  localparam int CTRL_RESET   = 5;
  // status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_SUSP    = 3;
  // timing: clock and bus phases
  localparam int  CLK_MHZ      = 100;
  localparam int  T_WP_NS      = 50;
  localparam int  T_WPH_NS     = 20;
  localparam int  T_RD_NS      = 120;
  localparam int  T_VCS_US     = 50;
  localparam int  T_SUSP_US    = 15;
  localparam int  WP_CYC   = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int  WPH_CYC  = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int  RD_CYC   = (T_RD_NS * CLK_MHZ + 999) / 1000 + 3;
  localparam int  VCS_CYC  = T_VCS_US * CLK_MHZ;
  localparam int  SUSP_CYC = T_SUSP_US * CLK_MHZ;
  localparam int  CNT_W    = 16;
endpackage
`default_nettype wire

// [flash_model.sv]
// behavioural flash device answering the host controller
`default_nettype none
module flash_model #(
  parameter int ERASE_RDS = 40 // status reads per erase
)(
  input  wire logic [17:0] flashAddr,  // address pins
  input  wire logic [7:0]  flashDqOut, // host data
  input  wire logic        flashDqOe,  // low: host drives
  input  wire logic        chipEn_n,   // chip enable
  input  wire logic        writeEn_n,  // write enable
  input  wire logic        outEn_n,    // output enable
  input  wire logic        failMode,   // erase ends failed
  output logic [7:0]       dq          // data to host
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] latA;
  logic [7:0]  mem [16];
  logic [7:0]  logD [64];
  logic [17:0] logA [64];
  logic        busy = 0;
  logic        susp = 0;
  logic        tog = 0;
  int          logN = 0;
  int          step = 0;
  int          left = 0;
  int          pgm = 0;
  initial dq = 8'h5a;
  // ====================
  // command decode
  function automatic int nxt(int s, logic [17:0] a, logic [7:0] d);
    if ((s==0 || s==3) && a==18'h555 && d==8'haa) return s+1;
    if ((s==1 || s==4) && a==18'h2aa && d==8'h55) return s+1;
    if (s==2 && a==18'h555 && d==8'h80) return 3;
    if (s==2 && a==18'h555 && d==8'ha0) return 7;
    if (s==5 && a==18'h555 && d==8'h10) return 6;
    return 0;
  endfunction
  task automatic cmd(input logic [17:0] a, input logic [7:0] d);
    if (busy)
    begin
      susp = d == 8'hb0;
      busy = !(d == 8'hb0 || d == 8'hf0);
    end
    else if (step == 7)
    begin
      mem[a[3:0]] = d;
      pgm = 3;
      step = 0;
    end
    else if (susp && (d == 8'h30 || d == 8'hf0))
    begin
      busy = d == 8'h30;
      susp = 0;
    end
    else
    begin
      step = nxt(step, a, d);
      if (susp && (step == 3 || step == 6)) step = 0;
      if (step == 6) left = ERASE_RDS;
      busy = step == 6;
      if (busy) step = 0;
    end
  endtask
  // ====================
  // pins: address at falling strobe, data at rising strobe
  always @(negedge writeEn_n) latA = flashAddr;
  always @(posedge writeEn_n)
  begin
    if (!chipEn_n && outEn_n)
    begin
      logA[logN] = latA;
      logD[logN] = flashDqOut;
      logN++;
      cmd(latA, flashDqOut);
    end
  end
  // each read edge flips the toggle bits; bit 3 low marks the erased block
  always @(negedge outEn_n)
  begin
    tog = !tog;
    if (pgm > 0)
      dq = {1'b0, tog, 3'b000, tog, 2'b00};
    else if (busy)
      dq = {1'b0, tog, failMode && left == 0, 2'b00, tog, 2'b00};
    else if (susp && !flashAddr[3])
      dq = {5'b01000, tog, 2'b00};
    else
      dq = mem[flashAddr[3:0]];
    if (pgm > 0) pgm--;
    if (busy && left > 0) left--;
    if (busy && left == 0 && !failMode) foreach (mem[i]) mem[i] = 8'hff;
    if (left == 0 && !failMode) busy = 0;
  end
  // a released bus never shows the last byte again
  always @(posedge outEn_n) dq = ~dq;
endmodule // flash_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the flash erase host controller
`default_nettype none
module testbench;
  import flash_erase_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        failMode = 0, err, pready, pslverr, flashDqOe;
  logic        chipEn_n, writeEn_n, outEn_n;
  logic [7:0]  paddr = 8'h00, flashDqOut, flashDqIn, dqDev;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [17:0] flashAddr;
  int          num_errors = 0, n_compared = 0, base = 0;
  assign flashDqIn = flashDqOe ? dqDev : flashDqOut;
  flash_erase_host #(.VCS_CYCLES(4), .SUSP_CYCLES(4)) flash_erase_host_i (
    .clk(clk), .rst_n(rst_n), .clkEn(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
    .chipEn_n(chipEn_n), .writeEn_n(writeEn_n), .outEn_n(outEn_n));
  flash_model flash_model_i (
    .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .chipEn_n(chipEn_n), .writeEn_n(writeEn_n), .outEn_n(outEn_n),
    .failMode(failMode), .dq(dqDev));
  // ====================
  // clock and hang guard
  initial forever #5 clk = ~clk;
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    results();
  end
  // ====================
  // apb master: hold everything until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ctrl(input int b);
    apb(1'b1, OFS_CTRL, 32'h1 << b);
  endtask
  // bounded status poll; the guard above ends a real hang
  task automatic waitBit(input int b, input logic v);
    for (int k = 0; k < 2000; k++)
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if (rd[b] === v) return;
    end
    check("status wait", rd[b], v);
  endtask
  function automatic logic [7:0] last();
    return flash_model_i.logD[flash_model_i.logN - 1];
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    num_errors += (seen !== exp);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ====================
  // test sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    check("ce idle", chipEn_n, 1'b1);
    waitBit(ST_BUSY, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", err, 1'b1);
    apb(1'b1, OFS_ADDR, 32'h3);
    apb(1'b0, OFS_ADDR, 32'h0);
    check("addr", rd, 32'h3);
    $display("test registers finished");
    // plain erase: six coded writes, then the array reads erased
    base = flash_model_i.logN;
    ctrl(CTRL_ERASE);
    waitBit(ST_DONE, 1'b1);
    check("fail clear", rd[ST_FAIL], 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      check("erase addr", flash_model_i.logA[base + k],
            (k == 1 || k == 4) ? 18'h2aa : 18'h555);
      check("erase data", flash_model_i.logD[base + k],
            k == 5 ? 8'h10 : k == 2 ? 8'h80 : k % 3 == 1 ? 8'h55 : 8'haa);
    end
    ctrl(CTRL_READ);
    waitBit(ST_DONE, 1'b1);
    apb(1'b0, OFS_DATA, 32'h0);
    check("erased byte", rd[7:0], 8'hff);
    $display("test erase finished");
    // failing erase, then reset returns the device to idle
    failMode <= 1'b1;
    ctrl(CTRL_ERASE);
    waitBit(ST_FAIL, 1'b1);
    ctrl(CTRL_RESET);
    waitBit(ST_DONE, 1'b1);
    check("reset code", last(), 8'hf0);
    check("device idle", flash_model_i.busy, 1'b0);
    failMode <= 1'b0;
    $display("test failure finished");
    // suspend refused while idle, then suspend, program, resume
    base = flash_model_i.logN;
    ctrl(CTRL_SUSPEND);
    repeat (30) @(posedge clk);
    check("idle suspend", flash_model_i.logN, base);
    ctrl(CTRL_ERASE);
    waitBit(ST_BUSY, 1'b1);
    ctrl(CTRL_SUSPEND);
    waitBit(ST_SUSP, 1'b1);
    check("suspend code", last(), 8'hb0);
    apb(1'b1, OFS_ADDR, 32'hc);
    apb(1'b1, OFS_DATA, 32'h3c);
    ctrl(CTRL_PROGRAM);
    waitBit(ST_DONE, 1'b1);
    check("program data", last(), 8'h3c);
    check("program code",
          flash_model_i.logD[flash_model_i.logN - 2], 8'ha0);
    ctrl(CTRL_READ);
    waitBit(ST_DONE, 1'b1);
    apb(1'b0, OFS_DATA, 32'h0);
    check("kept byte", rd[7:0], 8'h3c);
    ctrl(CTRL_RESUME);
    waitBit(ST_DONE, 1'b1);
    check("resume code", last(), 8'h30);
    $display("test suspend finished");
    results();
  end
endmodule // testbench
bind flash_erase_host flash_erase_host_monitor flash_erase_host_monitor_i (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .flashAddr(flashAddr),
  .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .chipEn_n(chipEn_n),
  .writeEn_n(writeEn_n), .outEn_n(outEn_n));
`default_nettype wire
